// ==== design/sync_sram_map.vh ====
`ifndef SYNC_SRAM_MAP_VH
`define SYNC_SRAM_MAP_VH
// Array geometry
`define SRAM_ADDR_W 21
`define SRAM_WORDS 2097152
`define SRAM_DATA_W 32
`define SRAM_PAR_W 4
`define SRAM_LANES 4
`define SRAM_LANE_W 9
// Burst order strap values
`define BURST_LINEAR 1'b0
`define BURST_INTERLEAVE 1'b1
// Reset values
`define BURST_CNT_RST 2'h0
`define ADDR_RST 21'h000000
// Sleep entry and exit latency in clock cycles
`define SLEEP_LAT_CYC 2'h2
`endif

// ==== design/burst_counter.v ====
`timescale 1ns/1ps
`include "sync_sram_map.vh"
module burst_counter (
    // Clock, reset, enable
    input wire sys_clk,
    input wire resetn,
    input wire clk_en,
    // Control
    input wire load,
    input wire [1:0] start_addr,
    input wire advance,
    input wire burst_order,
    // Current low address
    output wire [1:0] burst_low_addr
);
    reg [1:0] start_reg;
    reg [1:0] step_reg;

    // Start and step count; the low address is derived from both
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            start_reg <= `BURST_CNT_RST;
            step_reg <= `BURST_CNT_RST;
        end else if (clk_en) begin
            if (load) begin
                start_reg <= start_addr;
                step_reg <= 2'h0;
            end else if (advance) begin
                step_reg <= step_reg + 2'h1;
            end
        end
    end

    // XOR for interleaved, modulo-four add for linear
    assign burst_low_addr = (burst_order == `BURST_INTERLEAVE) ?
        (start_reg ^ step_reg) : (start_reg + step_reg);
endmodule // burst_counter

// ==== design/sync_sram.v ====
`timescale 1ns/1ps
`include "sync_sram_map.vh"
// Contract
// - Holds 2M words of 36 bits, inputs and outputs registered.
// - Every synchronous input is captured on the rising clock edge.
// - Address and chip enables load only when an address strobe is low.
// - Loading copies the two lowest address bits into the burst counter.
// - Counter advances on each edge where advance is sampled low.
// - With both strobes low, only the processor strobe counts.
// - Processor strobe ignored while first chip enable is high.
// - Selected only when enables are low, high, low at load time.
// - Global write low writes all bytes regardless of byte controls.
// - Any combination of lanes written; others keep their contents.
// - Address, data and controls registered, then write self-timed.
// - Read data appears on the same edge that registers the address.
// - Data and parity driven while output enable low, else inputs.
// - Outputs stay off the first read clock after deselect.
// - A registered deselect takes effect within a single cycle.
// - Bursts sustain a two-one-one-one clock pattern.
// - Strap low is linear, high interleaved; static during use.
// - Sleep input high enters low power and keeps data.
// - Scan inputs taken on rising test clock, output on falling edge.
// - Processor-strobe writes: controls taken at second edge, two clocks.
// - Interleaved XORs start with step; linear counts up modulo four.
// - Data pins released whenever a write cycle is detected; here only from the edge that registers the write.
module sync_sram (
    // Clock, reset, enable
    input wire sys_clk,
    input wire resetn,
    input wire clk_en,
    // Address and strobes
    input wire [20:0] addr,
    input wire proc_addr_strobe_n,
    input wire ctrl_addr_strobe_n,
    input wire burst_advance_n,
    // Chip enables
    input wire chip_sel_first_n,
    input wire chip_sel_second,
    input wire chip_sel_third_n,
    // Write controls
    input wire global_write_n,
    input wire byte_write_en_n,
    input wire [3:0] byte_lane_sel_n,
    // Output enable, sleep and strap
    input wire output_en_n,
    input wire sleep_req,
    input wire burst_mode,
    // Data and parity pins
    input wire [31:0] data_in,
    output wire [31:0] data_out,
    output wire data_oe,
    input wire [3:0] parity_in,
    output wire [3:0] parity_out,
    output wire parity_oe,
    // Boundary-scan edge
    input wire scan_clk,
    input wire scan_data_in,
    input wire scan_mode,
    output wire scan_data_out,
    // Status
    output wire sleeping
);
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_WRITE = 2'h2;
    localparam ST_PWR = 2'h3;

    // Full storage; lane k is data[8k+7:8k] plus parity[k]
    reg [35:0] mem [0:`SRAM_WORDS-1];

    // Access state and registered address
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [20:0] addr_reg;
    reg [1:0] burst_start_reg;

    // Burst order strap, taken once after reset
    reg strap_reg;
    reg strap_taken_reg;

    // Read pipeline and output drive qualifiers
    reg [35:0] rd_data_reg;
    reg drive_reg;
    reg fresh_reg;
    reg proc_wr_reg;

    // Sleep entry and exit counter
    reg [1:0] sleep_cnt_reg;
    reg sleep_reg;

    // Scan edge flops
    reg scan_in_reg;
    reg scan_mode_reg;
    reg scan_out_reg;

    // Strobe decode
    wire proc_take;
    wire ctrl_take;
    wire load;
    wire selected;

    // Write path
    wire ctrl_write;
    wire [3:0] wr_lanes;
    wire [35:0] wr_word;
    wire do_write;

    // Burst addressing
    wire [1:0] burst_low_addr;
    wire [20:0] cur_addr;
    wire advance;
    wire [1:0] next_low;

    // Lane mask from the write controls; global write overrides lanes.
    // Byte enable with no lane selected counts as no write at all,
    // so such a cycle behaves as a read.
    function [3:0] lane_mask;
        input gw_n;
        input bwe_n;
        input [3:0] sel_n;
        begin
            if (!gw_n)
                lane_mask = 4'hf;
            else if (!bwe_n)
                lane_mask = ~sel_n;
            else
                lane_mask = 4'h0;
        end
    endfunction

    // Strobe qualification; the processor strobe wins but needs enable 1
    assign proc_take = !proc_addr_strobe_n && !chip_sel_first_n;
    assign ctrl_take = !ctrl_addr_strobe_n && proc_addr_strobe_n;
    assign load = (proc_take || ctrl_take) && !sleep_reg;
    assign selected = !chip_sel_first_n && chip_sel_second &&
        !chip_sel_third_n;
    assign wr_lanes = lane_mask(global_write_n, byte_write_en_n,
        byte_lane_sel_n);
    assign ctrl_write = ctrl_take && (wr_lanes != 4'h0);
    assign advance = !burst_advance_n && !load && !sleep_reg;
    assign cur_addr = {addr_reg[20:2], burst_low_addr};
    assign wr_word = {parity_in[3], data_in[31:24], parity_in[2],
        data_in[23:16], parity_in[1], data_in[15:8], parity_in[0],
        data_in[7:0]};

    burst_counter u_burst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .load(load && selected),
        .start_addr(addr[1:0]),
        .advance(advance && (state_reg != ST_IDLE)),
        .burst_order(strap_reg),
        .burst_low_addr(burst_low_addr)
    );

    // Access state: what the registered cycle does. A new load always
    // wins over the running burst; sleep wins over both, since any
    // access pending at sleep entry is not guaranteed to complete.
    // A deselect returns to idle at once, dropping drive next edge.
    always @* begin
        state_next = state_reg;
        if (sleep_reg) begin
            state_next = ST_PWR;
        end else if (load) begin
            if (!selected)
                state_next = ST_IDLE;
            else if (ctrl_write)
                state_next = ST_WRITE;
            else
                state_next = ST_READ;
        end else begin
            case (state_reg)
                ST_IDLE: state_next = ST_IDLE;
                ST_READ: begin
                    if (wr_lanes != 4'h0)
                        state_next = ST_WRITE;
                end
                ST_WRITE: begin
                    if (wr_lanes == 4'h0 && !proc_wr_reg)
                        state_next = ST_READ;
                end
                ST_PWR: state_next = ST_IDLE;
                default: state_next = ST_IDLE;
            endcase
        end
    end

    // A write on the current registered address this edge
    assign do_write = !sleep_reg && !load && (state_reg != ST_IDLE) &&
        (state_reg != ST_PWR) && (wr_lanes != 4'h0);

    // Control registers and strap capture after reset release
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            addr_reg <= `ADDR_RST;
            strap_reg <= `BURST_INTERLEAVE;
            strap_taken_reg <= 1'b0;
            burst_start_reg <= `BURST_CNT_RST;
            drive_reg <= 1'b0;
            fresh_reg <= 1'b0;
            proc_wr_reg <= 1'b0;
        end else if (clk_en) begin
            // Strap is static, so one capture suffices
            if (!strap_taken_reg) begin
                strap_reg <= burst_mode;
                strap_taken_reg <= 1'b1;
            end
            state_reg <= state_next;
            // Start of burst kept here for the read-ahead address
            if (load && selected) begin
                addr_reg <= addr;
                burst_start_reg <= addr[1:0];
            end
            // First read after a deselect keeps pins released
            fresh_reg <= load && selected && (state_reg == ST_IDLE ||
                state_reg == ST_PWR);
            // Processor writes take controls at the second edge
            proc_wr_reg <= load && selected && proc_take;
            drive_reg <= (state_next == ST_READ) && !ctrl_write &&
                !do_write;
        end
    end

    // Array write, lane-masked, and pipelined read register. The read
    // register fetches one word ahead so each burst word costs a clock.
    always @(posedge sys_clk) begin
        if (clk_en) begin
            if (ctrl_write && selected && !sleep_reg) begin
                if (wr_lanes[0]) mem[{addr[20:2], addr[1:0]}][8:0] <=
                    wr_word[8:0];
                if (wr_lanes[1]) mem[addr][17:9] <= wr_word[17:9];
                if (wr_lanes[2]) mem[addr][26:18] <= wr_word[26:18];
                if (wr_lanes[3]) mem[addr][35:27] <= wr_word[35:27];
            end else if (do_write) begin
                if (wr_lanes[0]) mem[cur_addr][8:0] <= wr_word[8:0];
                if (wr_lanes[1]) mem[cur_addr][17:9] <= wr_word[17:9];
                if (wr_lanes[2]) mem[cur_addr][26:18] <= wr_word[26:18];
                if (wr_lanes[3]) mem[cur_addr][35:27] <= wr_word[35:27];
            end
            if (load && selected)
                rd_data_reg <= mem[addr];
            else if (advance && state_reg != ST_IDLE)
                rd_data_reg <= mem[{addr_reg[20:2],
                    next_low}];
        end
    end

    // Low address one step on from the current one. The step count is
    // recovered from the current address and the burst start, so the
    // counter module needs no extra port for it.
    function [1:0] u_next_low;
        input [1:0] cur;
        input [1:0] start;
        input order;
        reg [1:0] step;
        begin
            if (order == `BURST_INTERLEAVE) begin
                // Interleaved: step is the XOR distance from the start
                step = (cur ^ start) + 2'h1;
                u_next_low = start ^ step;
            end else begin
                // Linear: wraps modulo four from the start
                step = cur - start;
                step = step + 2'h1;
                u_next_low = start + step;
            end
        end
    endfunction

    // Read-ahead address for the next advance of the burst
    assign next_low = u_next_low(burst_low_addr, burst_start_reg,
        strap_reg);

    // Sleep entry and exit take two clocks; contents are kept.
    // Strobes are ignored while asleep; the master must deselect
    // first and keep the strobes quiet during recovery.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sleep_cnt_reg <= 2'h0;
            sleep_reg <= 1'b0;
        end else if (clk_en) begin
            if (sleep_req != sleep_reg) begin
                if (sleep_cnt_reg == `SLEEP_LAT_CYC - 2'h1) begin
                    sleep_reg <= sleep_req;
                    sleep_cnt_reg <= 2'h0;
                end else begin
                    sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
                end
            end else begin
                sleep_cnt_reg <= 2'h0;
            end
        end
    end

    // Pins drive only for reads with output enable low. Output enable
    // is asynchronous, so it gates the drive directly rather than
    // through a flop; a write releases the pins only from the edge that registers it.
    assign data_oe = drive_reg && !fresh_reg && !output_en_n &&
        !sleep_reg && (wr_lanes == 4'h0 || state_reg != ST_WRITE);
    assign parity_oe = data_oe;
    assign data_out = {rd_data_reg[34:27], rd_data_reg[25:18],
        rd_data_reg[16:9], rd_data_reg[7:0]};
    assign parity_out = {rd_data_reg[35], rd_data_reg[26],
        rd_data_reg[17], rd_data_reg[8]};
    assign sleeping = sleep_reg;

    // Scan edge: sample on rising test clock. Only the bypass path is
    // modelled; the test clock is independent of the system clock.
    always @(posedge scan_clk or negedge resetn) begin
        if (!resetn) begin
            scan_in_reg <= 1'b0;
            scan_mode_reg <= 1'b0;
        end else begin
            scan_in_reg <= scan_data_in;
            scan_mode_reg <= scan_mode;
        end
    end

    // Scan edge: shift out on falling test clock (bypass path only)
    always @(negedge scan_clk or negedge resetn) begin
        if (!resetn)
            scan_out_reg <= 1'b0;
        else
            scan_out_reg <= scan_in_reg & ~scan_mode_reg;
    end
    assign scan_data_out = scan_out_reg;
endmodule // sync_sram

// ==== testbench/sram_props.sv ====
`timescale 1ns/1ps
module sram_props (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Strobes, enables and write controls
    input wire proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
    input wire chip_sel_first_n, chip_sel_second, chip_sel_third_n,
    input wire global_write_n, byte_write_en_n, output_en_n, sleep_req,
    // Observed outputs
    input wire [31:0] data_out,
    input wire data_oe, parity_oe, sleeping
);
    // Decoded bus cycle
    wire sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
    wire ld = (!proc_addr_strobe_n && !chip_sel_first_n) ||
        (!ctrl_addr_strobe_n && proc_addr_strobe_n);
    wire wr = !global_write_n || !byte_write_en_n;
    // Read data is unknown until a first read has loaded it
    reg rd_seen_reg = 1'b0;
    always @(posedge sys_clk) begin
        if (ld && sel && !wr)
            rd_seen_reg <= 1'b1;
    end
    wire quiet = rd_seen_reg && !ld && burst_advance_n && !wr &&
        !sleep_req;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_oe_masked: assert property (output_en_n |-> !data_oe)
        else $error("pins driven with oe high");
    chk_lane_pair: assert property (parity_oe == data_oe)
        else $error("parity drive differs");
    chk_desel_off: assert property (ld && !sel |=> !data_oe)
        else $error("drive after deselect");
    chk_fresh_read: assert property (
        (ld && !sel) ##1 (ld && sel && !wr) |=> !data_oe)
        else $error("drive on first read");
    chk_ctrl_wr_off: assert property (
        !ctrl_addr_strobe_n && proc_addr_strobe_n && sel && wr |=> !data_oe)
        else $error("drive during write");
    chk_proc_wr_off: assert property (
        (!proc_addr_strobe_n && sel) ##1
        (proc_addr_strobe_n && ctrl_addr_strobe_n && wr) |=> !data_oe)
        else $error("drive during second write cycle");
    chk_out_hold: assert property (quiet [*3] |=> $stable(data_out))
        else $error("read data moved while idle");
    chk_sleep_in: assert property (
        $rose(sleep_req) |-> ##[1:3] sleeping)
        else $error("sleep not entered");
    chk_sleep_out: assert property (
        $fell(sleep_req) |-> ##[1:3] !sleeping)
        else $error("sleep not left");
endmodule // sram_props

bind sync_sram sram_props chk (.*);

// ==== testbench/bus_master.sv ====
`timescale 1ns/1ps
module bus_master (
    // Device and master sides of the shared pins
    input wire sys_clk,
    input wire [31:0] data_out,
    input wire [3:0] parity_out,
    input wire data_oe,
    input wire [35:0] mst_data,
    input wire mst_oe,
    // Level seen on the pins
    output wire [35:0] pins
);
    reg [35:0] last_reg = 36'h0;
    // Released pins flip, so a stale value never reads as good
    assign pins = (data_oe && mst_oe) ? 36'hx :
        data_oe ? {parity_out, data_out} :
        mst_oe ? mst_data : ~last_reg;
    // Last level, for the released case
    always @(posedge sys_clk) begin
        last_reg <= pins;
    end
endmodule // bus_master

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    // Bench-driven pins, quiet at time zero
    reg sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, mst_oe = 1'b0;
    reg proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1;
    reg burst_advance_n = 1'b1, global_write_n = 1'b1;
    reg byte_write_en_n = 1'b1, chip_sel_first_n = 1'b0;
    reg chip_sel_second = 1'b1, chip_sel_third_n = 1'b0;
    reg output_en_n = 1'b0, sleep_req = 1'b0, burst_mode = 1'b1;
    reg scan_clk = 1'b0, scan_data_in = 1'b0, scan_mode = 1'b0;
    reg [20:0] addr = 21'h0;
    reg [3:0] byte_lane_sel_n = 4'hf;
    reg [35:0] mst_data = 36'h0;
    // Device outputs and resolved pins
    wire [35:0] pins;
    wire [31:0] data_in = pins[31:0];
    wire [3:0] parity_in = pins[35:32];
    wire [31:0] data_out;
    wire [3:0] parity_out;
    wire data_oe, parity_oe, scan_data_out, sleeping;
    integer err_total = 0, num_checks = 0, cyc = 0, i;
    sync_sram uut (.*);
    bus_master bm (.*);
    // 50 MHz clock
    initial forever #10 sys_clk = ~sys_clk;
    // Hang guard, far above the expected run
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            err_total = err_total + 1;
            summarize;
        end
    end
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input string w, input [35:0] e, input [35:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("[FAIL] %0s exp %h got %h", w, e, g);
        end
    endtask
    // Controls packed as strobes, advance, writes, select
    task drv(input [5:0] k, input [3:0] l, input [20:0] a,
        input [35:0] d, input m);
        @(posedge sys_clk);
        proc_addr_strobe_n <= k[5];
        ctrl_addr_strobe_n <= k[4];
        burst_advance_n <= k[3];
        global_write_n <= k[2];
        byte_write_en_n <= k[1];
        chip_sel_first_n <= !k[0];
        chip_sel_third_n <= !k[0];
        byte_lane_sel_n <= l;
        addr <= a;
        mst_data <= d;
        mst_oe <= m;
        output_en_n <= m;
    endtask
    task rd(input [20:0] a, input [35:0] e);
        drv(6'b101111, 4'hf, a, 36'h0, 1'b0);
        drv(6'b111111, 4'hf, 21'h0, 36'h0, 1'b0);
        @(posedge sys_clk);
        #1 check("read data", e, {parity_out, data_out});
    endtask
    task do_reset(input m);
        @(posedge sys_clk);
        resetn <= 1'b0;
        burst_mode <= m;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    task t_write;
        drv(6'b101001, 4'he, 21'h10, 36'h9a1b2c3d4, 1'b1);
        rd(21'h10, 36'h9a1b2c3d4);
        drv(6'b101101, 4'ha, 21'h10, 36'h655667788, 1'b1);
        rd(21'h10, 36'hca166c388);
        @(posedge sys_clk);
        #1 check("pins", 36'hca166c388, pins);
        $display("t_write done");
    endtask
    task t_proc;
        drv(6'b101011, 4'hf, 21'h20, 36'h0, 1'b1);
        drv(6'b011011, 4'hf, 21'h20, 36'hfffffffff, 1'b1);
        drv(6'b111101, 4'he, 21'h0, 36'h100000055, 1'b1);
        rd(21'h20, 36'h100000055);
        $display("t_proc done");
    endtask
    task t_sleep;
        drv(6'b101110, 4'hf, 21'h10, 36'h0, 1'b0);
        drv(6'b111111, 4'hf, 21'h0, 36'h0, 1'b0);
        sleep_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 check("sleeping", 36'h1, {35'h0, sleeping});
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        repeat (6) @(posedge sys_clk);
        drv(6'b101110, 4'hf, 21'h0, 36'h0, 1'b0);
        drv(6'b101111, 4'hf, 21'h20, 36'h0, 1'b0);
        drv(6'b111111, 4'hf, 21'h0, 36'h0, 1'b0);
        #1 check("fresh oe", 36'h0, {35'h0, data_oe});
        @(posedge sys_clk);
        #1 check("read data", 36'h100000055, {parity_out, data_out});
        check("oe", 36'h1, {35'h0, data_oe});
        $display("t_sleep done");
    endtask
    task t_freeze;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        rd(21'h20, 36'hca166c388);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        $display("t_freeze done");
    endtask
    task t_burst(input [7:0] seq);
        for (i = 0; i < 4; i = i + 1)
            drv(6'b101011, 4'hf, 21'h30 + i[1:0],
                36'h500000030 + i[1:0], 1'b1);
        drv(6'b011111, 4'hf, 21'h31, 36'h0, 1'b0);
        drv(6'b110111, 4'hf, 21'h0, 36'h0, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            if (i > 0)
                @(posedge sys_clk);
            #1 check("burst", 36'h500000030 + seq[2*i+:2],
                {parity_out, data_out});
        end
        drv(6'b111111, 4'hf, 21'h0, 36'h0, 1'b0);
        $display("t_burst done");
    endtask
    // Main sequence; strap changes only under reset
    initial begin
        do_reset(1'b1);
        t_write;
        t_freeze;
        t_proc;
        t_sleep;
        t_burst(8'hb1);
        do_reset(1'b0);
        t_burst(8'h39);
        summarize;
    end
endmodule // testbench
